// *** hdl/nfc_host.sv ***
`timescale 1ns/1ps
module nfc_host
  import nfc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic REQ_VALID,
  input wire nfc_req_t REQ,
  output logic REQ_READY,
  input wire logic [DATA_W-1:0] WR_DATA,
  input wire logic WR_VALID,
  output logic WR_READY,
  output logic [DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic BUSY,
  input wire logic WRITE_EN,
  output logic [BLK_W-1:0] CUR_BLOCK,
  output logic [PIB_W-1:0] CUR_PAGE,
  output logic NF_CE_N,
  output logic NF_CLE,
  output logic NF_ALE,
  output logic NF_WE_N,
  output logic NF_RE_N,
  output logic NF_WP_N,
  input wire logic [DATA_W-1:0] NF_IO_IN,
  output logic [DATA_W-1:0] NF_IO_OUT,
  output logic NF_IO_OE,
  input wire logic NF_RB
);

  // ==========================================================
  // Declarations
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_CMD, S_ADDR, S_DGAP, S_DATA, S_CGAP, S_CMD2, S_WB, S_RBW, S_END
  } nfc_state_t;

  nfc_state_t state_reg;
  nfc_state_t state_next;
  nfc_state_t st_after_cmd;
  nfc_state_t st_after_addr;
  nfc_state_t st_after_data;
  nfc_state_t st_after_cmd2;
  nfc_req_t req_reg;
  logic phase_reg;
  logic phase_next;
  logic [1:0] aidx_reg;
  logic [1:0] aidx_next;
  logic [COL_W-1:0] cnt_reg;
  logic [COL_W-1:0] cnt_next;
  logic [COL_W-1:0] len_eff;
  logic [TMR_W-1:0] wp_cnt_reg;
  logic req_take;
  logic rd_capture;
  logic fifo_pop;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic is_write;
  logic is_read;
  logic wp_ok;
  logic drive_next;
  logic strobe_we_next;

  // ==========================================================
  // Helpers
  nfc_timer u_timer (
    .clk(MCLK),
    .rst_n(RESET_N),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  // Stalls the data phase when empty, so user back-pressure is real
  nfc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(RESET_N),
    .in_data(WR_DATA),
    .in_valid(WR_VALID),
    .in_ready(WR_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign is_write = (req_reg.dir == NFC_DIR_WRITE);
  assign is_read = (req_reg.dir == NFC_DIR_READ);
  assign wp_ok = (wp_cnt_reg == TMR_ZERO);
  // Never run past one page register
  assign len_eff = (req_reg.len > PAGE_BYTES) ? PAGE_BYTES : req_reg.len;

  // ==========================================================
  // Sequence planning
  always_comb begin
    st_after_cmd2 = req_reg.wait_rb ? S_WB : S_END;
    st_after_data = req_reg.cmd2_en ? S_CGAP : st_after_cmd2;
    st_after_addr = ((req_reg.dir != NFC_DIR_NONE) && (len_eff != '0)) ? S_DGAP : st_after_data;
    st_after_cmd = (req_reg.addr_cycles != 3'h0) ? S_ADDR : st_after_addr;
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    aidx_next = aidx_reg;
    cnt_next = cnt_reg;
    req_take = 1'b0;
    rd_capture = 1'b0;
    fifo_pop = 1'b0;
    unique case (state_reg)
      S_IDLE: begin
        if (REQ_VALID && REQ_READY) begin
          req_take = 1'b1;
          state_next = S_SETUP;
        end
      end
      S_SETUP: begin
        // Chip select leads the first strobe by a full cycle
        if (wp_ok) begin
          state_next = S_CMD;
          phase_next = 1'b0;
        end
      end
      S_CMD, S_CMD2: begin
        if (!phase_reg) begin
          phase_next = 1'b1;
        end else begin
          phase_next = 1'b0;
          if (state_reg == S_CMD2) begin
            state_next = st_after_cmd2;
          end else begin
            state_next = st_after_cmd;
            aidx_next = req_reg.row_only ? ROW_FIRST_IDX : 2'h0;
            // No address bytes: data count must be loaded here, not after the last address
            cnt_next = (req_reg.addr_cycles != 3'h0) ? COL_W'(req_reg.addr_cycles) : len_eff;
          end
        end
      end
      S_ADDR: begin
        if (!phase_reg) begin
          phase_next = 1'b1;
        end else begin
          phase_next = 1'b0;
          aidx_next = aidx_reg + 2'h1;
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == 12'h001 || aidx_reg == 2'h3) begin
            state_next = st_after_addr;
            cnt_next = len_eff;
          end
        end
      end
      S_DGAP: begin
        if (tmr_done && (is_read || fifo_valid)) begin
          state_next = S_DATA;
          phase_next = 1'b0;
          fifo_pop = is_write;
        end
      end
      S_DATA: begin
        if (!phase_reg) begin
          phase_next = 1'b1;
          // Access delay of 20 ns fits inside the 25 ns low cycle
          rd_capture = is_read;
        end else begin
          phase_next = 1'b0;
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == 12'h001) begin
            state_next = st_after_data;
          end else if (is_write && !fifo_valid) begin
            state_next = S_DGAP;
          end else begin
            fifo_pop = is_write;
          end
        end
      end
      S_CGAP: begin
        if (tmr_done) begin
          state_next = S_CMD2;
          phase_next = 1'b0;
        end
      end
      S_WB: begin
        // Busy may take up to 100 ns to appear after the last strobe
        if (tmr_done) begin
          state_next = S_RBW;
        end
      end
      S_RBW: begin
        if (NF_RB) begin
          state_next = S_END;
        end
      end
      S_END: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Gap timer loads
  always_comb begin
    tmr_load = (state_next != state_reg)
        && (state_next == S_DGAP || state_next == S_CGAP || state_next == S_WB);
    unique case (state_next)
      S_DGAP: tmr_val = is_read ? T_WHR_CYC : TMR_ZERO;
      S_CGAP: tmr_val = T_RHW_CYC;
      S_WB: tmr_val = T_WB_CYC;
      default: tmr_val = TMR_ZERO;
    endcase
  end

  // ==========================================================
  // Sequencer state
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= S_IDLE;
      phase_reg <= 1'b0;
      aidx_reg <= 2'h0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      aidx_reg <= aidx_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_reg <= '0;
      CUR_BLOCK <= '0;
      CUR_PAGE <= '0;
    end else if (req_take) begin
      req_reg <= REQ;
      CUR_BLOCK <= nfc_block_index(REQ.row);
      CUR_PAGE <= nfc_page_in_block(REQ.row);
    end
  end

  // ==========================================================
  // Pins, registered from the next state
  assign drive_next = (state_next == S_CMD) || (state_next == S_CMD2)
      || (state_next == S_ADDR) || (state_next == S_DATA && is_write);
  assign strobe_we_next = drive_next && !phase_next;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      NF_CE_N <= 1'b1;
      NF_CLE <= 1'b0;
      NF_ALE <= 1'b0;
      NF_WE_N <= 1'b1;
      NF_RE_N <= 1'b1;
      NF_IO_OE <= 1'b0;
      NF_IO_OUT <= 8'h00;
    end else begin
      NF_CE_N <= (state_next == S_IDLE) || (state_next == S_END);
      NF_CLE <= (state_next == S_CMD) || (state_next == S_CMD2);
      NF_ALE <= (state_next == S_ADDR);
      NF_WE_N <= !strobe_we_next;
      NF_RE_N <= !(state_next == S_DATA && is_read && !phase_next);
      NF_IO_OE <= drive_next;
      if (!phase_next) begin
        unique case (state_next)
          S_CMD: NF_IO_OUT <= req_reg.cmd1;
          S_CMD2: NF_IO_OUT <= req_reg.cmd2;
          S_ADDR: NF_IO_OUT <= nfc_addr_byte(aidx_next, req_reg.col, req_reg.row);
          S_DATA: NF_IO_OUT <= is_write ? fifo_data : NF_IO_OUT;
          default: NF_IO_OUT <= NF_IO_OUT;
        endcase
      end
    end
  end

  // ==========================================================
  // Write protect follows the enable, with settle time after release
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      NF_WP_N <= 1'b0;
      wp_cnt_reg <= TMR_ZERO;
    end else begin
      NF_WP_N <= WRITE_EN;
      if (WRITE_EN && !NF_WP_N) begin
        wp_cnt_reg <= T_WW_CYC;
      end else if (wp_cnt_reg != TMR_ZERO) begin
        wp_cnt_reg <= wp_cnt_reg - 4'h1;
      end
    end
  end

  // ==========================================================
  // User status and read data
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REQ_READY <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else begin
      REQ_READY <= (state_next == S_IDLE);
      BUSY <= (state_next != S_IDLE);
      DONE <= (state_reg == S_END);
    end
  end

  // No stall on read data: the consumer must take every byte
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= rd_capture;
      if (rd_capture) begin
        RD_DATA <= NF_IO_IN;
      end
    end
  end

endmodule

// *** hdl/nfc_pkg.sv ***
// ==========================================================
// Overview of operation
// - Command byte taken on write strobe rise while command latch is high.
// - Address byte taken on write strobe rise while address latch is high.
// - Full address is four address cycles, assembled to column and row.
// - Column 12 bits: byte 0 bits 7..0, byte 1 bits 11..8, top nibble low.
// - Row 16 bits: byte 2 bits 7..0, byte 3 bits 15..8, LSB on line 0.
// - Host must tolerate bad blocks; 1004 to 1024 blocks are valid.
package nfc_pkg;

  // ==========================================================
  // Geometry
  localparam int DATA_W = 8;
  localparam int COL_W = 12;
  localparam int ROW_W = 16;
  localparam int BLK_W = 10;
  localparam int PIB_W = 6;
  localparam int BLK_LSB = 6;
  localparam int PAGE_MAIN_BYTES = 2048;
  localparam int PAGE_SPARE_BYTES = 128;
  localparam logic [COL_W-1:0] PAGE_BYTES = 12'(PAGE_MAIN_BYTES + PAGE_SPARE_BYTES);
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS = 1024;
  localparam int MIN_VALID_BLOCKS = 1004;
  localparam logic [2:0] ADDR_CYCLES = 3'h4;
  localparam logic [1:0] ROW_FIRST_IDX = 2'h2;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Timing at 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WHR_NS = 60;
  localparam int T_RHW_NS = 30;
  localparam int T_WB_NS = 100;
  localparam int T_WW_NS = 100;
  localparam int TMR_W = 4;

  function automatic int nfc_min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [TMR_W-1:0] T_WHR_CYC = TMR_W'(nfc_min_cycles(T_WHR_NS));
  localparam logic [TMR_W-1:0] T_RHW_CYC = TMR_W'(nfc_min_cycles(T_RHW_NS));
  localparam logic [TMR_W-1:0] T_WB_CYC = TMR_W'(nfc_min_cycles(T_WB_NS));
  localparam logic [TMR_W-1:0] T_WW_CYC = TMR_W'(nfc_min_cycles(T_WW_NS));
  localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;

  // ==========================================================
  // Request carrier
  typedef enum logic [1:0] {NFC_DIR_NONE, NFC_DIR_WRITE, NFC_DIR_READ} nfc_dir_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [2:0] addr_cycles;
    logic row_only;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    nfc_dir_t dir;
    logic [COL_W-1:0] len;
    logic cmd2_en;
    logic [7:0] cmd2;
    logic wait_rb;
  } nfc_req_t;

  // ==========================================================
  // Address decoding
  function automatic logic [BLK_W-1:0] nfc_block_index(input logic [ROW_W-1:0] row);
    return row[ROW_W-1:BLK_LSB];
  endfunction

  function automatic logic [PIB_W-1:0] nfc_page_in_block(input logic [ROW_W-1:0] row);
    return row[BLK_LSB-1:0];
  endfunction

  function automatic logic [7:0] nfc_addr_byte(input logic [1:0] idx,
      input logic [COL_W-1:0] col, input logic [ROW_W-1:0] row);
    unique case (idx)
      2'h0: return col[7:0];
      2'h1: return {4'h0, col[11:8]};
      2'h2: return row[7:0];
      default: return row[15:8];
    endcase
  endfunction

endpackage

// *** hdl/nfc_timer.sv ***
`timescale 1ns/1ps
// ==========================================================
// Down counter for inter-strobe gaps
module nfc_timer
  import nfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [TMR_W-1:0] value,
  output logic done
);

  logic [TMR_W-1:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= TMR_ZERO;
    end else if (load) begin
      cnt_reg <= value;
    end else if (cnt_reg != TMR_ZERO) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  assign done = (cnt_reg == TMR_ZERO) && !load;

endmodule

// *** hdl/nfc_fifo.sv ***
`timescale 1ns/1ps
// ==========================================================
// Write data buffer, registered flags
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != (AW + 1)'(DEPTH));
      out_valid <= (count_next != '0);
    end
  end

endmodule

// *** testbench/nfc_monitor.sv ***
`timescale 1ns/1ps
// ==========================================================
// Pin-side checker
module nfc_monitor
  import nfc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic DONE,
  input wire logic BUSY,
  input wire logic WRITE_EN,
  input wire logic NF_CE_N,
  input wire logic NF_CLE,
  input wire logic NF_ALE,
  input wire logic NF_WE_N,
  input wire logic NF_RE_N,
  input wire logic NF_WP_N,
  input wire logic [DATA_W-1:0] NF_IO_OUT,
  input wire logic NF_IO_OE,
  input wire logic NF_RB
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  logic [2:0] acnt_reg;
  // Wraps past 7, but any excess shows, since the count passes 5 first
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acnt_reg <= 3'h0;
    end else if (NF_CLE) begin
      acnt_reg <= 3'h0;
    end else if ($rose(NF_WE_N) && NF_ALE) begin
      acnt_reg <= acnt_reg + 3'h1;
    end
  end
  // ==========================================================
  // Assertions
  AST_SELECTED: assert property ($fell(NF_WE_N) || $fell(NF_RE_N) |-> !NF_CE_N)
    else $error("strobe while deselected");
  AST_ONE_LATCH: assert property (!(NF_CLE && NF_ALE))
    else $error("both latches high");
  AST_WE_BYTE: assert property ($fell(NF_WE_N) |=> NF_WE_N && NF_IO_OE && $stable(NF_IO_OUT))
    else $error("write byte not held");
  AST_NO_CONTEND: assert property (!NF_RE_N |-> !NF_IO_OE)
    else $error("host drives bus in read");
  AST_RE_STEP: assert property ($fell(NF_RE_N) |=> NF_RE_N ##[0:2] RD_VALID)
    else $error("read byte not delivered");
  AST_ADDR_MAX: assert property (acnt_reg <= 3'h4)
    else $error("too many address cycles");
  AST_WP_FOLLOW: assert property ($past(RESET_N) |-> NF_WP_N == $past(WRITE_EN))
    else $error("protect pin wrong");
  AST_WAIT_READY: assert property (!NF_RB |-> !$fell(NF_WE_N) && !$fell(NF_RE_N))
    else $error("strobe while busy");
  AST_DONE_PULSE: assert property (DONE |-> REQ_READY && !BUSY ##1 !DONE)
    else $error("bad completion pulse");
endmodule
bind nfc_host nfc_monitor i_mon (.MCLK(MCLK), .RESET_N(RESET_N), .REQ_READY(REQ_READY),
  .RD_VALID(RD_VALID), .DONE(DONE), .BUSY(BUSY), .WRITE_EN(WRITE_EN), .NF_CE_N(NF_CE_N),
  .NF_CLE(NF_CLE), .NF_ALE(NF_ALE), .NF_WE_N(NF_WE_N), .NF_RE_N(NF_RE_N),
  .NF_WP_N(NF_WP_N), .NF_IO_OUT(NF_IO_OUT), .NF_IO_OE(NF_IO_OE), .NF_RB(NF_RB));

// *** testbench/nfc_flash_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Device model; command codes arbitrary
module nfc_flash_model #(
  parameter logic [7:0] C_PROG = 8'h31,
  parameter logic [7:0] C_PGO = 8'h32,
  parameter logic [7:0] C_RGO = 8'h34,
  parameter logic [7:0] C_EGO = 8'h36
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] shared_bus,
  output logic [7:0] dout,
  output logic dout_en,
  output logic rb_low
);
  logic [7:0] ab [4];
  logic [7:0] pb [int];
  // No bad blocks modelled, so block zero is always usable
  logic [7:0] mem [int][int];
  logic [11:0] column_index = 12'h000;
  logic [15:0] row_index = 16'h0000;
  int n = 0;
  initial begin
    dout = 8'h00;
    dout_en = 1'b0;
    rb_low = 1'b0;
  end
  task automatic assemble();
    if (n == 4) begin
      column_index = {ab[1][3:0], ab[0]};
      row_index = {ab[3], ab[2]};
    end
    if (n == 2) row_index = {ab[1], ab[0]};
    n = 0;
  endtask
  task automatic command(input logic [7:0] c);
    if (c == C_PROG) pb.delete();
    if (c != C_PGO && c != C_RGO && c != C_EGO) begin
      n = 0;
    end else begin
      assemble();
      if (c == C_RGO) begin
        pb.delete();
        if (mem.exists(row_index)) pb = mem[row_index];
      end else if (wp_n && c == C_PGO) begin
        mem[row_index] = pb;
      end else if (wp_n) begin
        for (int p = 0; p < 64; p++) mem.delete({row_index[15:6], p[5:0]});
      end
      fork
        begin
          #40 rb_low = 1'b1;
          #2000 rb_low = 1'b0;
        end
      join_none
    end
  endtask
  // Write strobes ignored while busy or deselected; read strobes ignored only while deselected
  always @(posedge we_n) begin
    if (!ce_n && !rb_low) begin
      if (cle) begin
        command(shared_bus);
      end else if (ale) begin
        ab[n[1:0]] = shared_bus;
        n++;
      end else begin
        if (n != 0) assemble();
        pb[column_index] = shared_bus;
        column_index++;
      end
    end
  end
  always @(negedge read_strobe_n) begin
    if (!ce_n) begin
      dout <= #20 pb.exists(column_index) ? pb[column_index] : 8'hFF;
      dout_en <= #20 1'b1;
      column_index++;
    end
  end
  // Held one cycle past release, then let go
  always @(posedge read_strobe_n) dout_en <= #25 1'b0;
endmodule

// *** testbench/nand_flash_pin_interface_tb.sv ***
`timescale 1ns/1ps
module nand_flash_pin_interface_tb
  import nfc_pkg::*;
;
  localparam logic [11:0] COL0 = 12'h83F;
  localparam logic [15:0] ROW0 = 16'hABCD;
  logic MCLK, RESET_N, REQ_VALID, REQ_READY, WR_VALID, WR_READY, RD_VALID, DONE, BUSY;
  logic WRITE_EN, NF_CE_N, NF_CLE, NF_ALE, NF_WE_N, NF_RE_N, NF_WP_N, NF_IO_OE, NF_RB;
  logic dev_en, rb_low;
  logic [7:0] WR_DATA, RD_DATA, NF_IO_IN, NF_IO_OUT, dev_q, last_bus;
  logic [BLK_W-1:0] CUR_BLOCK;
  logic [PIB_W-1:0] CUR_PAGE;
  nfc_req_t REQ;
  logic [7:0] rd_q [$];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  nfc_host i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .WR_DATA(WR_DATA), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DONE(DONE), .BUSY(BUSY), .WRITE_EN(WRITE_EN),
    .CUR_BLOCK(CUR_BLOCK), .CUR_PAGE(CUR_PAGE), .NF_CE_N(NF_CE_N), .NF_CLE(NF_CLE),
    .NF_ALE(NF_ALE), .NF_WE_N(NF_WE_N), .NF_RE_N(NF_RE_N), .NF_WP_N(NF_WP_N),
    .NF_IO_IN(NF_IO_IN), .NF_IO_OUT(NF_IO_OUT), .NF_IO_OE(NF_IO_OE), .NF_RB(NF_RB));
  nfc_flash_model i_mem (.ce_n(NF_CE_N), .cle(NF_CLE), .ale(NF_ALE), .we_n(NF_WE_N),
    .read_strobe_n(NF_RE_N), .wp_n(NF_WP_N), .shared_bus(NF_IO_IN), .dout(dev_q),
    .dout_en(dev_en), .rb_low(rb_low));
  // Floating bus toggles so a stale byte never passes
  assign NF_IO_IN = NF_IO_OE ? NF_IO_OUT : (dev_en && !NF_CE_N) ? dev_q : ~last_bus;
  assign NF_RB = !rb_low;
  always @(posedge MCLK) last_bus <= NF_IO_IN;
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic push_all(input int cnt, input logic [7:0] base);
    WR_VALID = 1'b1;
    for (int i = 0; i < cnt; i++) begin
      WR_DATA = base + 8'(i);
      do @(posedge MCLK); while (WR_READY !== 1'b1);
      #2;
    end
    WR_VALID = 1'b0;
  endtask
  task automatic run(input logic [7:0] c1, input logic [2:0] na, input logic [15:0] row,
      input nfc_dir_t d, input logic [11:0] len, input logic [7:0] c2);
    REQ = '{cmd1: c1, addr_cycles: na, row_only: na == 3'h2, col: COL0, row: row, dir: d,
      len: len, cmd2_en: c2 != 8'h00, cmd2: c2, wait_rb: c2 != 8'h00};
    REQ_VALID = 1'b1;
    do @(posedge MCLK); while (REQ_READY !== 1'b1);
    #2 REQ_VALID = 1'b0;
    rd_q.delete();
    do begin
      @(posedge MCLK);
      if (RD_VALID === 1'b1) rd_q.push_back(RD_DATA);
    end while (DONE !== 1'b1);
    #2;
    chk("busy", BUSY, 1'b0);
  endtask
  task automatic t_reset();
    chk("ce_n", NF_CE_N, 1'b1);
    chk("io_oe", NF_IO_OE, 1'b0);
    chk("wp_n", NF_WP_N, 1'b1);
  endtask
  task automatic t_read(input logic [7:0] base, input logic erased);
    run(8'h00, 3'h4, ROW0, NFC_DIR_NONE, 12'h000, i_mem.C_RGO);
    run(8'h00, 3'h0, ROW0, NFC_DIR_READ, 12'h020, 8'h00);
    chk("count", rd_q.size(), 32);
    foreach (rd_q[i]) chk("byte", rd_q[i], erased ? 8'hFF : base + 8'(i));
  endtask
  task automatic t_program();
    push_all(32, 8'hA0);
    chk("full", WR_READY, 1'b0);
    run(i_mem.C_PROG, 3'h4, ROW0, NFC_DIR_WRITE, 12'h020, i_mem.C_PGO);
    chk("column", i_mem.column_index, COL0 + 12'h020);
    chk("row", i_mem.row_index, ROW0);
    chk("block", CUR_BLOCK, ROW0[15:6]);
    chk("page", CUR_PAGE, ROW0[5:0]);
    chk("drained", WR_READY, 1'b1);
  endtask
  task automatic t_protect();
    WRITE_EN = 1'b0;
    push_all(4, 8'h50);
    chk("wp_n low", NF_WP_N, 1'b0);
    run(i_mem.C_PROG, 3'h4, ROW0, NFC_DIR_WRITE, 12'h004, i_mem.C_PGO);
    WRITE_EN = 1'b1;
    t_read(8'hA0, 1'b0);
  endtask
  task automatic t_erase();
    run(8'h00, 3'h2, ROW0 & 16'hFFC0, NFC_DIR_NONE, 12'h000, i_mem.C_EGO);
    chk("erase row", i_mem.row_index, ROW0 & 16'hFFC0);
    t_read(8'h00, 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    RESET_N = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    WR_DATA = 8'h00;
    WR_VALID = 1'b0;
    WRITE_EN = 1'b1;
    last_bus = 8'h00;
    repeat (3) @(posedge MCLK);
    #2 RESET_N = 1'b1;
    repeat (2) @(posedge MCLK);
    #2;
    t_reset();
    t_program();
    t_read(8'hA0, 1'b0);
    t_protect();
    t_erase();
    give_verdict();
  end
endmodule
